// File: inc/clkstrap_consts.svh
// Offsets, field positions, reset values and widths of the clock strap block
`ifndef CLKSTRAP_CONSTS_SVH
`define CLKSTRAP_CONSTS_SVH

`define CS_ADDR_W          8
`define CS_OFS_CTRL        8'h00
`define CS_OFS_STATUS      8'h04
`define CS_OFS_FREQ_CPU    8'h08
`define CS_OFS_FREQ_BUS    8'h0C

`define CS_CTRL_REF_DOUBLE 0
`define CS_CTRL_SIO_48     1
`define CS_CTRL_W          2
`define CS_CTRL_RESET      2'h0

`define CS_ST_FS_LSB       0
`define CS_ST_STYLE        4
`define CS_ST_MULT         5
`define CS_ST_PM           6
`define CS_ST_ENABLED      7
`define CS_ST_PG_SEEN      8
`define CS_ST_POWERDOWN    9

`define CS_MEM_PAIRS       6
`define CS_PCI_STOPPABLE   4

`endif

// File: inc/clkstrap_pkg.sv
// Types shared by the clock strap block
package clkstrap_pkg;
  typedef enum logic [1:0] {
    ST_POR     = 2'b00,
    ST_WAIT_PG = 2'b01,
    ST_RUN     = 2'b11
  } strap_state_t;

  typedef struct packed {
    logic [3:0] fs;
    logic       cpu_style;
    logic       current_mult;
    logic       pm_mode;
  } strap_t;

  typedef struct packed {
    logic [15:0] cpu;
    logic [15:0] agp;
    logic [15:0] pci;
  } freq_t;
endpackage

// File: src/clkstrap.sv
// Strap capture, power-good gate and output configuration of the clock chip
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "clkstrap_consts.svh"

// Overview of operation
// - Strap pins read, latched, then drive clocks
// - Frequency strap decoded to CPU/AGP/PCI rates
// - Push-pull: first low power-good latches, enables
// - Power-good ignored after first low
// - Style strap 1 push-pull, 0 open-drain
// - Open-drain: gate off, pin gives reference
// - CPU pair push-pull or open-drain by style
// - Multiplier strap: 4x when 0, 6x when 1
// - Reference A strength selectable, single default
// - Six memory pairs copy buffer input, inverted
// - PCI clocks synchronous with CPU clocks
// - Bit2 pin SIO 24/48, bit3 USB 48
// - Bit1 pin becomes free-running PCI clock
// - PCI halt stops stoppable PCI at low
// - Mode strap 0 enables halt, powerdown pins
// - Powerdown input low enters powerdown mode
module clkstrap
  import clkstrap_pkg::*;
(
  input  wire logic                   REF_CLK,
  input  wire logic                   RESETN,
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [`CS_ADDR_W-1:0]  PADDR,
  input  wire logic [31:0]            PWDATA,
  output logic      [31:0]            PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  input  wire logic [3:0]             FREQ_SELECT_STRAP_I,
  output logic      [3:0]             FREQ_SELECT_STRAP_O,
  output logic      [3:0]             FREQ_SELECT_STRAP_OE,
  input  wire logic                   CPU_STYLE_STRAP_I,
  output logic                        CPU_STYLE_STRAP_O,
  output logic                        CPU_STYLE_STRAP_OE,
  input  wire logic                   CURRENT_MULT_STRAP_I,
  output logic                        CURRENT_MULT_STRAP_O,
  output logic                        CURRENT_MULT_STRAP_OE,
  input  wire logic                   PM_MODE_STRAP_I,
  output logic                        PM_MODE_STRAP_O,
  output logic                        PM_MODE_STRAP_OE,
  input  wire logic                   POWER_GOOD_GATE_N_I,
  output logic                        POWER_GOOD_GATE_N_O,
  output logic                        POWER_GOOD_GATE_N_OE,
  output logic                        CPU_CLK_TRUE_O,
  output logic                        CPU_CLK_TRUE_OE,
  output logic                        CPU_CLK_COMP_O,
  output logic                        CPU_CLK_COMP_OE,
  output logic      [1:0]             CHIPSET_CPU_CLK_PAIR,
  output logic      [`CS_PCI_STOPPABLE-1:0] PCI_CLK,
  input  wire logic                   MEM_BUF_IN,
  output logic      [`CS_MEM_PAIRS-1:0] MEM_CLK_TRUE,
  output logic      [`CS_MEM_PAIRS-1:0] MEM_CLK_COMP,
  input  wire logic                   PCI_HALT_N,
  input  wire logic                   CPU_HALT_N,
  input  wire logic                   POWERDOWN_N,
  output logic                        REF_A_DOUBLE_DRIVE,
  output logic                        CPU_DRIVE_6X,
  output logic                        POWERDOWN_ACTIVE
);

  function automatic freq_t decode_freq(input logic [3:0] code);
    freq_t f;
    f = '{16'h1A18, 16'h1A18, 16'h0D0C};
    unique case (code)
      4'h0: f = '{16'h1A18, 16'h1A18, 16'h0D0C};
      4'h1: f = '{16'h2724, 16'h1A18, 16'h0D0C};
      4'h2: f = '{16'h2EE0, 16'h1770, 16'h0BB8};
      4'h3: f = '{16'h3415, 16'h1A0B, 16'h0D05};
      4'h4: f = '{16'h1C20, 16'h1C20, 16'h0E10};
      4'h5: f = '{16'h2904, 16'h1B58, 16'h0DAC};
      4'h6: f = '{16'h3E80, 16'h1900, 16'h0C80};
      4'h7: f = '{16'h36B0, 16'h1B58, 16'h0DAC};
      4'h8: f = '{16'h1E14, 16'h1E14, 16'h0F0A};
      4'h9: f = '{16'h2AF8, 16'h1CA5, 16'h0E53};
      4'hA: f = '{16'h4650, 16'h1770, 16'h0BB8};
      4'hB: f = '{16'h3A98, 16'h1770, 16'h0BB8};
      4'hC: f = '{16'h2328, 16'h1770, 16'h0BB8};
      4'hD: f = '{16'h2710, 16'h1A0B, 16'h0D05};
      4'hE: f = '{16'h4E20, 16'h1A0B, 16'h0D05};
      4'hF: f = '{16'h3415, 16'h1A0B, 16'h0D05};
    endcase
    return f;
  endfunction

  strap_state_t              state;
  strap_state_t              next_state;
  strap_t                    straps;
  strap_t                    next_straps;
  logic                      pg_seen;
  logic [`CS_CTRL_W-1:0]     ctrl;
  logic [1:0]                div;
  logic                      cpu_lvl;
  logic                      pci_lvl;
  logic                      pci_stop_lvl;
  logic                      sio_lvl;
  logic                      fast_lvl;

  // Strap sequencing: first edge after release is the supply crossing
  wire  por_exit   = (state == ST_POR);
  wire  wait_pg    = (state == ST_WAIT_PG);
  wire  run        = (state == ST_RUN);
  wire  pg_low     = wait_pg && !POWER_GOOD_GATE_N_I;
  wire  pm_enabled = run && !straps.pm_mode;
  wire  pd_req     = pm_enabled && !POWERDOWN_N;
  wire  pci_halt   = pm_enabled && !PCI_HALT_N;
  wire  cpu_halt   = pm_enabled && !CPU_HALT_N;
  wire  clk_en     = run && !pd_req;
  wire  od_mode    = !straps.cpu_style;
  freq_t freq;
  assign freq = decode_freq(straps.fs);

  always_comb begin
    next_state  = state;
    next_straps = straps;
    unique case (state)
      ST_POR: begin
        next_straps.cpu_style = CPU_STYLE_STRAP_I;
        next_straps.pm_mode   = PM_MODE_STRAP_I;
        if (CPU_STYLE_STRAP_I) begin
          next_state = ST_WAIT_PG;
        end else begin
          next_straps.fs           = FREQ_SELECT_STRAP_I;
          next_straps.current_mult = CURRENT_MULT_STRAP_I;
          next_state               = ST_RUN;
        end
      end
      ST_WAIT_PG: begin
        if (pg_low) begin
          next_straps.fs           = FREQ_SELECT_STRAP_I;
          next_straps.current_mult = CURRENT_MULT_STRAP_I;
          next_state               = ST_RUN;
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_POR;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      state   <= ST_POR;
      straps  <= '0;
      pg_seen <= 1'b0;
    end else begin
      state   <= next_state;
      straps  <= next_straps;
      pg_seen <= pg_seen || pg_low;
    end
  end

  // Clock phase generation: PCI and SIO from one divider, fast level toggles every cycle, CPU level too except in CPU halt
  wire next_pci_lvl  = div[0] ? !pci_lvl : pci_lvl;
  wire pci_hold_low  = pci_halt && !pci_stop_lvl;
  wire next_pci_stop = pci_hold_low ? 1'b0 : next_pci_lvl;
  wire next_sio_lvl  = (ctrl[`CS_CTRL_SIO_48] || (div == 2'b11)) ?
                       !sio_lvl : sio_lvl;

  always_ff @(posedge REF_CLK) begin
    if (!RESETN || !clk_en) begin
      div          <= 2'b00;
      cpu_lvl      <= 1'b0;
      pci_lvl      <= 1'b0;
      pci_stop_lvl <= 1'b0;
      sio_lvl      <= 1'b0;
      fast_lvl     <= 1'b0;
    end else begin
      div          <= div + 2'b01;
      cpu_lvl      <= cpu_halt ? 1'b0 : !cpu_lvl;
      pci_lvl      <= next_pci_lvl;
      pci_stop_lvl <= next_pci_stop;
      sio_lvl      <= next_sio_lvl;
      // Reference and USB rate, not stopped by CPU halt
      fast_lvl     <= !fast_lvl;
    end
  end

  // Pin roles after latching
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      FREQ_SELECT_STRAP_O   <= 4'h0;
      FREQ_SELECT_STRAP_OE  <= 4'h0;
      CPU_STYLE_STRAP_O     <= 1'b0;
      CPU_STYLE_STRAP_OE    <= 1'b0;
      PM_MODE_STRAP_O       <= 1'b0;
      PM_MODE_STRAP_OE      <= 1'b0;
      CURRENT_MULT_STRAP_O  <= 1'b0;
      CURRENT_MULT_STRAP_OE <= 1'b0;
      POWER_GOOD_GATE_N_O   <= 1'b0;
      POWER_GOOD_GATE_N_OE  <= 1'b0;
    end else begin
      FREQ_SELECT_STRAP_O   <= {!fast_lvl && clk_en,
                                next_sio_lvl && clk_en,
                                next_pci_lvl && clk_en,
                                !fast_lvl && clk_en};
      FREQ_SELECT_STRAP_OE  <= {4{run}};
      CPU_STYLE_STRAP_O     <= next_pci_lvl && clk_en;
      CPU_STYLE_STRAP_OE    <= !por_exit;
      PM_MODE_STRAP_O       <= next_pci_lvl && clk_en;
      PM_MODE_STRAP_OE      <= !por_exit;
      CURRENT_MULT_STRAP_O  <= next_pci_stop && clk_en;
      CURRENT_MULT_STRAP_OE <= run;
      POWER_GOOD_GATE_N_O   <= !fast_lvl && clk_en;
      POWER_GOOD_GATE_N_OE  <= run && od_mode;
    end
  end

  // Processor, chipset, PCI and memory clocks
  wire next_cpu = !cpu_lvl && clk_en && !cpu_halt;
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      CPU_CLK_TRUE_O       <= 1'b0;
      CPU_CLK_TRUE_OE      <= 1'b0;
      CPU_CLK_COMP_O       <= 1'b0;
      CPU_CLK_COMP_OE      <= 1'b0;
      CHIPSET_CPU_CLK_PAIR <= 2'b00;
      PCI_CLK              <= '0;
      MEM_CLK_TRUE         <= '0;
      MEM_CLK_COMP         <= '1;
      CPU_DRIVE_6X         <= 1'b0;
      POWERDOWN_ACTIVE     <= 1'b0;
    end else begin
      // Open drain only pulls low; released means high on the board
      CPU_CLK_TRUE_O       <= od_mode ? 1'b0 : next_cpu;
      CPU_CLK_TRUE_OE      <= od_mode ? (run && !next_cpu) : run;
      CPU_CLK_COMP_O       <= od_mode ? 1'b0 : (clk_en && !next_cpu);
      CPU_CLK_COMP_OE      <= od_mode ? (clk_en && next_cpu) : run;
      CHIPSET_CPU_CLK_PAIR <= {clk_en && !next_cpu, next_cpu};
      PCI_CLK              <= {`CS_PCI_STOPPABLE{next_pci_stop && clk_en}};
      MEM_CLK_TRUE         <= {`CS_MEM_PAIRS{MEM_BUF_IN}};
      MEM_CLK_COMP         <= {`CS_MEM_PAIRS{!MEM_BUF_IN}};
      CPU_DRIVE_6X         <= run && straps.current_mult;
      POWERDOWN_ACTIVE     <= pd_req;
    end
  end

  // APB slave: one wait-free access cycle, registered answer
  wire setup    = PSEL && !PENABLE;
  wire wr_fire  = PSEL && PENABLE && PWRITE && PREADY;
  wire hit_ctrl = (PADDR == `CS_OFS_CTRL);
  wire hit_stat = (PADDR == `CS_OFS_STATUS);
  wire hit_fcpu = (PADDR == `CS_OFS_FREQ_CPU);
  wire hit_fbus = (PADDR == `CS_OFS_FREQ_BUS);
  wire hit_any  = hit_ctrl || hit_stat || hit_fcpu || hit_fbus;
  wire [31:0] status_word = {22'h00_0000, pd_req, pg_seen, clk_en,
                             straps.pm_mode, straps.current_mult,
                             straps.cpu_style, straps.fs};
  wire [31:0] read_word =
    hit_ctrl ? {30'h0000_0000, ctrl} :
    hit_stat ? status_word :
    hit_fcpu ? {16'h0000, freq.cpu} :
    hit_fbus ? {freq.agp, freq.pci} : 32'h0000_0000;

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup && !hit_any;
      PRDATA  <= (setup && !PWRITE) ? read_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      ctrl               <= `CS_CTRL_RESET;
      REF_A_DOUBLE_DRIVE <= 1'b0;
    end else begin
      if (wr_fire && hit_ctrl) begin
        ctrl <= PWDATA[`CS_CTRL_W-1:0];
      end
      REF_A_DOUBLE_DRIVE <= ctrl[`CS_CTRL_REF_DOUBLE];
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  strap_hold_a: assert property (run |=> $stable(straps))
    else $error("latched straps changed while running");
  pg_ignored_a: assert property (run |=> run ##1 run)
    else $error("left run state after power-good latch");
  pg_latch_a: assert property (
    pg_low |=> run && straps.fs == $past(FREQ_SELECT_STRAP_I)
               ##1 FREQ_SELECT_STRAP_OE == 4'hF)
    else $error("power-good low did not latch and enable");
  od_skip_gate_a: assert property (
    por_exit && !CPU_STYLE_STRAP_I |=> run ##1 POWER_GOOD_GATE_N_OE)
    else $error("open-drain mode did not bypass power-good");
  cpu_od_low_a: assert property (
    run && od_mode |-> ##1 !CPU_CLK_TRUE_O && !CPU_CLK_COMP_O)
    else $error("open-drain CPU pin drove high");
  mem_invert_a: assert property (MEM_CLK_COMP == ~MEM_CLK_TRUE)
    else $error("memory complement not inverted");
  mem_follow_a: assert property (
    1'b1 |=> MEM_CLK_TRUE == {`CS_MEM_PAIRS{$past(MEM_BUF_IN)}})
    else $error("memory clock does not follow buffer input");
  mult_drive_a: assert property (
    run |=> CPU_DRIVE_6X == $past(straps.current_mult))
    else $error("drive multiplier does not match strap");
  freq_code3_a: assert property (
    straps.fs == 4'h3 |-> freq.cpu == 16'h3415 && freq.pci == 16'h0D05)
    else $error("code 0011 decoded wrongly");
  pci_stop_a: assert property (
    (pci_halt && clk_en && !pci_stop_lvl) [*2] |-> ##1 PCI_CLK == '0)
    else $error("stoppable PCI clock ran while halted");
  pd_enter_a: assert property (
    pd_req |=> POWERDOWN_ACTIVE ##1 PCI_CLK == '0)
    else $error("powerdown not entered");
  cpu_pair_comp_a: assert property (
    clk_en && !od_mode |=> CPU_CLK_COMP_O == !CPU_CLK_TRUE_O)
    else $error("push-pull CPU complement not inverted");
  pci_sync_a: assert property (
    clk_en && !pci_halt |=> PCI_CLK[0] == FREQ_SELECT_STRAP_O[1])
    else $error("stoppable PCI out of step with free PCI");
  cpu_halt_a: assert property (
    cpu_halt |=> !CPU_CLK_TRUE_O && !CHIPSET_CPU_CLK_PAIR[0])
    else $error("CPU clock ran while halted");
  usb_rate_a: assert property (
    clk_en [*2] |=> $changed(FREQ_SELECT_STRAP_O[3]))
    else $error("USB clock did not toggle");
  pins_input_a: assert property (
    !run |=> FREQ_SELECT_STRAP_OE == 4'h0 && !CURRENT_MULT_STRAP_OE)
    else $error("strap pin driven before latch");
  pm_ignore_a: assert property (
    run && straps.pm_mode |=> !POWERDOWN_ACTIVE)
    else $error("powerdown honoured with mode strap high");
  ref_default_a: assert property (
    !ctrl[`CS_CTRL_REF_DOUBLE] |=> !REF_A_DOUBLE_DRIVE)
    else $error("reference A double drive without request");

endmodule // clkstrap
`default_nettype wire

// File: test/clk_board.sv
// Board model: strap resistors and power-good source behind the shared pins
`timescale 1ns/1ps
`default_nettype none
module clk_board (
  input  wire logic [3:0] fs_level,
  input  wire logic [3:0] misc_level,
  input  wire logic [3:0] fs_o,
  input  wire logic [3:0] fs_oe,
  input  wire logic [3:0] misc_o,
  input  wire logic [3:0] misc_oe,
  output logic      [3:0] fs_pin,
  output logic      [3:0] misc_pin
);
  // Resistor level shows only while the device leaves the pin undriven
  assign fs_pin   = (fs_oe & fs_o) | (~fs_oe & fs_level);
  assign misc_pin = (misc_oe & misc_o) | (~misc_oe & misc_level);
endmodule // clk_board
`default_nettype wire

// File: test/clkstrap_tb.sv
// Self-checking bench for the clock strap block
`timescale 1ns/1ps
`default_nettype none
`include "clkstrap_consts.svh"
module clkstrap_tb
  import clkstrap_pkg::*;
;
  typedef struct {
    logic [31:0] data;
    logic [31:0] mask;
    logic        err;
  } note_t;
  localparam int LIMIT = 20000;
  logic        REF_CLK = 1'b0, RESETN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
  logic        PWRITE = 1'b0, MEM_BUF_IN = 1'b0, PCI_HALT_N = 1'b1;
  logic        CPU_HALT_N = 1'b1, POWERDOWN_N = 1'b1;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA;
  logic        PREADY, PSLVERR, REF_A_DOUBLE_DRIVE, CPU_DRIVE_6X;
  logic        POWERDOWN_ACTIVE, CPU_CLK_TRUE_O, CPU_CLK_TRUE_OE;
  logic [3:0]  FREQ_SELECT_STRAP_O, FREQ_SELECT_STRAP_OE, PCI_CLK;
  logic [3:0]  fs_level = 4'h0, misc_level = 4'hF;
  logic [5:0]  MEM_CLK_TRUE, MEM_CLK_COMP;
  wire  logic [3:0] fs_pin, misc_pin, misc_o, misc_oe;
  note_t       notes[$];
  note_t       cur;
  freq_t       tbl [16] = '{
    48'h1A18_1A18_0D0C, 48'h2724_1A18_0D0C, 48'h2EE0_1770_0BB8,
    48'h3415_1A0B_0D05, 48'h1C20_1C20_0E10, 48'h2904_1B58_0DAC,
    48'h3E80_1900_0C80, 48'h36B0_1B58_0DAC, 48'h1E14_1E14_0F0A,
    48'h2AF8_1CA5_0E53, 48'h4650_1770_0BB8, 48'h3A98_1770_0BB8,
    48'h2328_1770_0BB8, 48'h2710_1A0B_0D05, 48'h4E20_1A0B_0D05,
    48'h3415_1A0B_0D05};
  int          n_mismatch = 0, comparisons = 0, cycles = 0, seed = 76535;
  int          i;
  logic [2:0]  m;
  logic [31:0] ones = 32'hFFFF_FFFF;
  logic [3:0]  s0, s1, s2;

  clk_board board (.fs_level, .misc_level, .fs_o(FREQ_SELECT_STRAP_O),
    .fs_oe(FREQ_SELECT_STRAP_OE), .misc_o, .misc_oe, .fs_pin, .misc_pin);

  clkstrap dut (
    .REF_CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .FREQ_SELECT_STRAP_I(fs_pin), .FREQ_SELECT_STRAP_O,
    .FREQ_SELECT_STRAP_OE, .CPU_STYLE_STRAP_I(misc_pin[0]),
    .CPU_STYLE_STRAP_O(misc_o[0]), .CPU_STYLE_STRAP_OE(misc_oe[0]),
    .CURRENT_MULT_STRAP_I(misc_pin[1]), .CURRENT_MULT_STRAP_O(misc_o[1]),
    .CURRENT_MULT_STRAP_OE(misc_oe[1]), .PM_MODE_STRAP_I(misc_pin[2]),
    .PM_MODE_STRAP_O(misc_o[2]), .PM_MODE_STRAP_OE(misc_oe[2]),
    .POWER_GOOD_GATE_N_I(misc_pin[3]), .POWER_GOOD_GATE_N_O(misc_o[3]),
    .POWER_GOOD_GATE_N_OE(misc_oe[3]), .CPU_CLK_TRUE_O, .CPU_CLK_TRUE_OE,
    .CPU_CLK_COMP_O(), .CPU_CLK_COMP_OE(), .CHIPSET_CPU_CLK_PAIR(), .PCI_CLK,
    .MEM_BUF_IN, .MEM_CLK_TRUE, .MEM_CLK_COMP, .PCI_HALT_N, .CPU_HALT_N,
    .POWERDOWN_N, .REF_A_DOUBLE_DRIVE, .CPU_DRIVE_6X, .POWERDOWN_ACTIVE
  );

  always #20 REF_CLK = ~REF_CLK;

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check_bus(input string what, input logic [31:0] exp, act);
    comparisons++;
    if (act !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, act);
    end
  endtask

  task automatic check_pin(input string what, input logic [7:0] exp, act);
    check_bus(what, {24'h0, exp}, {24'h0, act});
  endtask

  always @(posedge REF_CLK) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      finish_test();
    end
  end

  // Completed transfer: compare against the oldest note
  always @(posedge REF_CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1) begin
      cur = notes.pop_front();
      check_bus("prdata", cur.data & cur.mask, PRDATA & cur.mask);
      check_bus("pslverr", {31'h0, cur.err}, {31'h0, PSLVERR});
    end
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, exp, mask, input logic err);
    notes.push_back('{exp, mask, err});
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do @(posedge REF_CLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic power_up(input logic [3:0] fs, input logic [2:0] ms);
    int k;
    @(posedge REF_CLK);
    RESETN <= 1'b0;
    fs_level <= fs;
    misc_level <= {1'b1, ms};
    repeat (6) @(posedge REF_CLK);
    RESETN <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    if (ms[0])
      check_pin("oe_before_pg", 8'h00, {4'h0, FREQ_SELECT_STRAP_OE});
    misc_level[3] <= 1'b0;
    @(posedge REF_CLK);
    // Pin levels after the latch edge must not reach the configuration
    fs_level <= ~fs;
    misc_level[1] <= ~ms[1];
    for (k = 0; k < 20 && FREQ_SELECT_STRAP_OE !== 4'hF; k++)
      @(posedge REF_CLK);
    check_pin("clocks_on", 8'h0F, {4'h0, FREQ_SELECT_STRAP_OE});
  endtask

  task automatic sample3();
    @(negedge REF_CLK);
    s0 = {PCI_CLK[0], FREQ_SELECT_STRAP_O[3], FREQ_SELECT_STRAP_O[1],
          m[0] ? CPU_CLK_TRUE_O : CPU_CLK_TRUE_OE};
    @(negedge REF_CLK);
    s1 = {PCI_CLK[0], FREQ_SELECT_STRAP_O[3], FREQ_SELECT_STRAP_O[1],
          m[0] ? CPU_CLK_TRUE_O : CPU_CLK_TRUE_OE};
    @(negedge REF_CLK);
    s2 = {PCI_CLK[0], FREQ_SELECT_STRAP_O[3], FREQ_SELECT_STRAP_O[1],
          m[0] ? CPU_CLK_TRUE_O : CPU_CLK_TRUE_OE};
  endtask

  initial begin
    for (i = 0; i < 16; i++) begin
      m = 3'($random(seed));
      power_up(i[3:0], m);
      apb(1'b0, `CS_OFS_STATUS, 32'h0, {22'h0, 3'b011, m, i[3:0]},
          m[0] ? ones : 32'hFFFF_FEFF, 1'b0);
      apb(1'b0, `CS_OFS_FREQ_CPU, 32'h0, {16'h0, tbl[i].cpu}, ones, 1'b0);
      apb(1'b0, `CS_OFS_FREQ_BUS, 32'h0, {tbl[i].agp, tbl[i].pci}, ones,
          1'b0);
      @(negedge REF_CLK);
      check_pin("drive_6x", {7'h0, m[1]}, {7'h0, CPU_DRIVE_6X});
      check_pin("pg_pin_oe", {7'h0, ~m[0]}, {7'h0, misc_oe[3]});
      sample3();
      check_pin("fast_toggle", 8'h05, {4'h0, (s0 ^ s1) & 4'h5});
      check_pin("free_pci", 8'h02, {4'h0, (s0 ^ s2) & 4'h2});
      if (!m[0])
        check_pin("od_level", 8'h00, {7'h0, CPU_CLK_TRUE_O});
      @(posedge REF_CLK);
      MEM_BUF_IN <= 1'($random(seed));
      PCI_HALT_N <= 1'b0;
      CPU_HALT_N <= 1'b0;
      POWERDOWN_N <= 1'b0;
      @(posedge REF_CLK);
      @(negedge REF_CLK);
      check_pin("mem_true", {2'b0, {6{MEM_BUF_IN}}}, {2'b0, MEM_CLK_TRUE});
      check_pin("mem_comp", {2'b0, {6{~MEM_BUF_IN}}}, {2'b0, MEM_CLK_COMP});
      repeat (2) @(negedge REF_CLK);
      check_pin("pd_active", {7'h0, ~m[2]}, {7'h0, POWERDOWN_ACTIVE});
      @(posedge REF_CLK);
      POWERDOWN_N <= 1'b1;
      repeat (6) @(posedge REF_CLK);
      sample3();
      check_pin("pci_halt", {7'h0, m[2]}, {7'h0, s0[3] ^ s2[3] | s0[3]});
      check_pin("cpu_halt", {7'h0, m[2]}, {7'h0, s0[0] ^ s1[0]});
      @(posedge REF_CLK);
      PCI_HALT_N <= 1'b1;
      CPU_HALT_N <= 1'b1;
      $display("test strap code %0d done", i);
    end
    m = 3'b011;
    power_up(4'h3, m);
    @(posedge REF_CLK);
    misc_level[3] <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    misc_level[3] <= 1'b0;
    apb(1'b0, `CS_OFS_STATUS, 32'h0, 32'h0000_01B3, ones, 1'b0);
    apb(1'b1, `CS_OFS_STATUS, 32'($random(seed)), 32'h0, 32'h0, 1'b0);
    apb(1'b0, `CS_OFS_STATUS, 32'h0, 32'h0000_01B3, ones, 1'b0);
    apb(1'b0, `CS_OFS_CTRL, 32'h0, 32'h0000_0000, ones, 1'b0);
    check_pin("ref_single", 8'h00, {7'h0, REF_A_DOUBLE_DRIVE});
    apb(1'b1, `CS_OFS_CTRL, 32'h0000_0003, 32'h0, 32'h0, 1'b0);
    apb(1'b0, `CS_OFS_CTRL, 32'h0, 32'h0000_0003, ones, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'h0000_0000, ones, 1'b1);
    @(negedge REF_CLK);
    check_pin("ref_double", 8'h01, {7'h0, REF_A_DOUBLE_DRIVE});
    s0[0] = FREQ_SELECT_STRAP_O[2];
    @(negedge REF_CLK);
    check_pin("sio_48", {7'h0, ~s0[0]}, {7'h0, FREQ_SELECT_STRAP_O[2]});
    $display("test registers done");
    finish_test();
  end
endmodule // clkstrap_tb
`default_nettype wire
